// ==== flash_protect_params.svh ====
// constants for the flash sector protection and identification logic
// assumes inclusion by the package and both ends; definitions only
`ifndef FLASH_PROTECT_PARAMS_SVH
`define FLASH_PROTECT_PARAMS_SVH
// ============================================================
// geometry
`define SECTOR_COUNT        64
`define SECTOR_ADDR_BITS    6
`define BANK_ADDR_BITS      3
`define ADDR_BITS           22
`define DATA_BITS           16
// ============================================================
// commands (low data byte on a write cycle)
`define CMD_QUERY           8'h90
`define CMD_RESET           8'hF0
`define CMD_DPB_SET         8'hA1
`define CMD_DPB_CLEAR       8'hA0
`define CMD_DPB_STATUS      8'hA3
`define CMD_PROGRAM         8'hA5
`define CMD_ERASE           8'h30
`define CMD_LOCK_PROGRAM    8'hC0
// ============================================================
// reset values and identity (identity values are arbitrary)
`define DPB_RESET           1'b1
`define LOCK_RESET          1'b0
`define ID_MAKER            16'h00A5
`define ID_DEVICE           16'h5A3C
`define LOCK_RESERVED       15'h0000
// ============================================================
// timing, ns and cycles at 10 ns
`define CLOCK_PERIOD_NS     10
`define WRITE_GLITCH_NS     20
`define WRITE_GLITCH_CYC    ((`WRITE_GLITCH_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define POLL_NS             40
`define POLL_CYC            (`POLL_NS / `CLOCK_PERIOD_NS)
`define OPERATION_NS        200
`define OPERATION_CYC       (`OPERATION_NS / `CLOCK_PERIOD_NS)
`define SELECT_ACCESS_NS    50
`define SELECT_ACCESS_CYC   ((`SELECT_ACCESS_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// ==== flash_protect_pkg.sv ====
// types shared by both ends of the flash protection link
// assumes the params header is on the include path
`include "flash_protect_params.svh"
package flash_protect_pkg;
    typedef logic [`ADDR_BITS-1:0] addr_t;
    typedef logic [`DATA_BITS-1:0] data_t;
    typedef enum logic [1:0] {
        MODE_ARRAY,
        MODE_QUERY,
        MODE_STATUS
    } read_mode_e;
endpackage

// ==== flash_link_if.sv ====
// pins between the flash device end and its host
// resolves the shared data bus dq here from the two output enables
`timescale 1ns/10ps
`include "flash_protect_params.svh"
interface flash_link_if;
    import flash_protect_pkg::*;
    logic  select_n;
    logic  out_en_n;
    logic  write_en_n;
    logic  hw_reset_n;
    logic  prog_volt;
    logic  supply_low;
    addr_t addr;
    data_t host_dq;
    logic  host_dq_oe;
    data_t dev_dq;
    logic  dev_dq_oe;
    logic  busy;
    wire   [`DATA_BITS-1:0] dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);
    modport device (
        input  select_n, out_en_n, write_en_n, hw_reset_n, prog_volt, supply_low,
        input  addr, host_dq, host_dq_oe,
        output dev_dq, dev_dq_oe, busy
    );
    modport host (
        output select_n, out_en_n, write_en_n, hw_reset_n, prog_volt, supply_low,
        output addr, host_dq, host_dq_oe,
        input  dev_dq, dev_dq_oe, busy
    );
endinterface

// ==== flash_protect_device.sv ====
// What this block does
// - query mode drives id codes on sixteen bits
// - host puts sector address on top bits
// - bank-qualified query; other banks read array
// - host writes query command first
// - one volatile protect bit per sector, reset 1
// - set gives 0, clear gives 1, repeatable
// - reset returns all protect bits to 1
// - lock register program reverts protect bits
// - program/erase to protected sector ignored
// - protected sector attempt polls briefly then reads
// - status command reports sector protect bit
// - low program voltage locks all sectors
// - supply lockout refuses writes, resets to read
// - short write-enable pulses are filtered out
// - write needs select low, write low, output high
// - power-up with pins low accepts no command
// - lock register bit 0 only, rest reserved
// - standby floats outputs regardless of output enable
// - standby when select and reset high and not busy
// - host waits select access time after standby
// - deselect does not stop running operation
//
// device end: pins sampled through two flops; one write is taken at the
// filtered rising edge of write enable, command in the low data byte
`timescale 1ns/10ps
`include "flash_protect_params.svh"
module flash_protect_device
    import flash_protect_pkg::*;
(
    input  wire logic    i_clock,
    input  wire logic    i_rst,
    input  wire logic    i_clk_en,
    flash_link_if.device link,
    input  wire data_t   i_array_data,
    output logic         o_array_write,
    output logic         o_standby,
    output logic         o_lock_bit
);
    // ============================================================
    // pin synchronisers
    localparam int SW = 6 + `ADDR_BITS + `DATA_BITS;
    logic [SW-1:0] pin_meta_r;
    logic [SW-1:0] pin_r;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pin_meta_r <= '0;
            pin_r      <= '0;
        end else if (i_clk_en) begin
            pin_meta_r <= {link.select_n, link.out_en_n, link.write_en_n, link.hw_reset_n,
                           link.prog_volt, link.supply_low, link.addr, link.host_dq};
            pin_r      <= pin_meta_r;
        end
    end
    logic  sel_n, oe_n, we_n, rst_n, vpp, lockout;
    addr_t addr;
    data_t din;
    assign {sel_n, oe_n, we_n, rst_n, vpp, lockout, addr, din} = pin_r;
    wire [`SECTOR_ADDR_BITS-1:0] sector = addr[`ADDR_BITS-1 -: `SECTOR_ADDR_BITS];
    wire [`BANK_ADDR_BITS-1:0]   bank   = addr[`ADDR_BITS-1 -: `BANK_ADDR_BITS];

    // ============================================================
    // write enable glitch filter and write detection
    logic [3:0] low_cnt_r;
    logic       we_armed_r;
    logic       powered_r;
    wire        write_pulse = we_n && we_armed_r && !sel_n && oe_n;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            low_cnt_r  <= '0;
            we_armed_r <= 1'b0;
        end else if (i_clk_en) begin
            if (we_n || sel_n || !oe_n) begin
                low_cnt_r <= '0;
            end else if (low_cnt_r < 4'(`WRITE_GLITCH_CYC)) begin
                low_cnt_r <= low_cnt_r + 4'h1;
            end
            // armed only after a low pulse of the full filter width
            we_armed_r <= !we_n && !sel_n && oe_n && (low_cnt_r >= 4'(`WRITE_GLITCH_CYC));
        end
    end
    // powered is hardware reset delayed one cycle; writes while reset low are dropped
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            powered_r <= 1'b0;
        end else if (i_clk_en) begin
            powered_r <= rst_n;
        end
    end
    wire write_ok = write_pulse && powered_r && rst_n && !lockout;

    // ============================================================
    // protect bits, lock bit and command state
    logic [`SECTOR_COUNT-1:0]   dpb_r;
    logic                       lock_r;
    read_mode_e                 mode_r;
    logic [`BANK_ADDR_BITS-1:0] query_bank_r;
    logic                       query_bank_en_r;
    logic [4:0]                 busy_cnt_r;
    logic                       busy_r;
    logic [`SECTOR_ADDR_BITS-1:0] status_sector_r;
    wire  [7:0] cmd = din[7:0];
    wire        sector_locked = !dpb_r[sector] || !vpp;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dpb_r <= {`SECTOR_COUNT{`DPB_RESET}};
        end else if (i_clk_en) begin
            if (!rst_n && powered_r) begin
                dpb_r <= {`SECTOR_COUNT{`DPB_RESET}};
            end else if (write_ok && !busy_r && cmd == `CMD_LOCK_PROGRAM) begin
                dpb_r <= {`SECTOR_COUNT{`DPB_RESET}};
            end else if (write_ok && !busy_r && cmd == `CMD_DPB_SET) begin
                dpb_r[sector] <= 1'b0;
            end else if (write_ok && !busy_r && cmd == `CMD_DPB_CLEAR) begin
                dpb_r[sector] <= 1'b1;
            end
        end
    end

    // non-volatile in the array; modelled as a flop that only programs once
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            lock_r <= `LOCK_RESET;
        end else if (i_clk_en) begin
            if (write_ok && !busy_r && cmd == `CMD_LOCK_PROGRAM) begin
                lock_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mode_r          <= MODE_ARRAY;
            query_bank_r    <= '0;
            query_bank_en_r <= 1'b0;
            status_sector_r <= '0;
        end else if (i_clk_en) begin
            if (lockout || !rst_n || !powered_r) begin
                mode_r <= MODE_ARRAY;
            end else if (write_ok && !busy_r) begin
                case (cmd)
                    `CMD_QUERY: begin
                        mode_r          <= MODE_QUERY;
                        query_bank_r    <= bank;
                        query_bank_en_r <= din[8];
                    end
                    `CMD_DPB_STATUS: begin
                        mode_r          <= MODE_STATUS;
                        status_sector_r <= sector;
                    end
                    `CMD_RESET:      mode_r <= MODE_ARRAY;
                    default:         mode_r <= mode_r;
                endcase
            end
        end
    end

    // ============================================================
    // program/erase engine: protected targets only poll briefly
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            busy_r        <= 1'b0;
            busy_cnt_r    <= '0;
            o_array_write <= 1'b0;
        end else if (i_clk_en) begin
            o_array_write <= 1'b0;
            if (lockout || !rst_n) begin
                busy_r     <= 1'b0;
                busy_cnt_r <= '0;
            end else if (busy_r) begin
                // select is not consulted, so deselecting does not stop it
                busy_cnt_r <= busy_cnt_r - 5'h1;
                busy_r     <= (busy_cnt_r != 5'h1);
            end else if (write_ok && (cmd == `CMD_PROGRAM || cmd == `CMD_ERASE)) begin
                busy_r <= 1'b1;
                if (sector_locked) begin
                    busy_cnt_r <= 5'(`POLL_CYC);
                end else begin
                    busy_cnt_r    <= 5'(`OPERATION_CYC);
                    o_array_write <= 1'b1;
                end
            end
        end
    end

    // ============================================================
    // read path
    wire   standby  = sel_n && rst_n && !busy_r;
    wire   in_bank  = !query_bank_en_r || (bank == query_bank_r);
    data_t rdata;
    always_comb begin
        rdata = i_array_data;
        case (mode_r)
            MODE_QUERY: begin
                if (in_bank) begin
                    case (addr[1:0])
                        2'h0:    rdata = `ID_MAKER;
                        2'h1:    rdata = `ID_DEVICE;
                        2'h2:    rdata = {15'h0000, !dpb_r[sector]};
                        default: rdata = {`LOCK_RESERVED, lock_r};
                    endcase
                end
            end
            MODE_STATUS: rdata = {15'h0000, dpb_r[status_sector_r]};
            MODE_ARRAY:  rdata = i_array_data;
            default:     rdata = i_array_data;
        endcase
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            link.dev_dq    <= '0;
            link.dev_dq_oe <= 1'b0;
            link.busy      <= 1'b0;
            o_standby      <= 1'b0;
            o_lock_bit     <= `LOCK_RESET;
        end else if (i_clk_en) begin
            link.dev_dq    <= rdata;
            link.dev_dq_oe <= !standby && !sel_n && !oe_n && we_n && rst_n;
            link.busy      <= busy_r;
            o_standby      <= standby;
            o_lock_bit     <= lock_r;
        end
    end
endmodule // flash_protect_device

// ==== flash_protect_host.sv ====
// host end: turns one user request into a pin-level write or read cycle
// assumes the device end samples its pins through two flops
`timescale 1ns/10ps
`include "flash_protect_params.svh"
module flash_protect_host
    import flash_protect_pkg::*;
(
    input  wire logic    i_clock,
    input  wire logic    i_rst,
    input  wire logic    i_clk_en,
    flash_link_if.host   link,
    input  wire logic    i_req,
    input  wire logic    i_write,
    input  wire addr_t   i_addr,
    input  wire data_t   i_wdata,
    input  wire logic    i_prog_volt,
    input  wire logic    i_supply_low,
    input  wire logic    i_release_reset,
    output logic         o_ready,
    output logic         o_rvalid,
    output data_t        o_rdata
);
    typedef enum {ST_IDLE, ST_WRITE, ST_WRITE_END, ST_READ, ST_GAP} host_state_e;
    host_state_e state_r;
    logic [3:0]  cnt_r;
    // ============================================================
    // pin drive; writes keep output enable high and hold write low long
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_r         <= ST_IDLE;
            cnt_r           <= '0;
            link.select_n   <= 1'b1;
            link.out_en_n   <= 1'b1;
            link.write_en_n <= 1'b1;
            link.hw_reset_n <= 1'b0;
            link.prog_volt  <= 1'b1;
            link.supply_low <= 1'b0;
            link.addr       <= '0;
            link.host_dq    <= '0;
            link.host_dq_oe <= 1'b0;
            o_ready         <= 1'b0;
            o_rvalid        <= 1'b0;
            o_rdata         <= '0;
        end else if (i_clk_en) begin
            link.hw_reset_n <= i_release_reset;
            link.prog_volt  <= i_prog_volt;
            link.supply_low <= i_supply_low;
            o_rvalid        <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    o_ready <= i_release_reset;
                    if (i_req && o_ready) begin
                        o_ready         <= 1'b0;
                        link.addr       <= i_addr;
                        link.host_dq    <= i_wdata;
                        link.select_n   <= 1'b0;
                        link.host_dq_oe <= i_write;
                        link.write_en_n <= !i_write;
                        link.out_en_n   <= i_write;
                        cnt_r           <= '0;
                        state_r         <= i_write ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'(`WRITE_GLITCH_CYC + 3)) begin
                        link.write_en_n <= 1'b1;
                        state_r         <= ST_WRITE_END;
                    end
                end
                ST_WRITE_END: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'(`WRITE_GLITCH_CYC + 6)) begin
                        link.select_n   <= 1'b1;
                        link.host_dq_oe <= 1'b0;
                        cnt_r           <= '0;
                        state_r         <= ST_GAP;
                    end
                end
                ST_READ: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'(`SELECT_ACCESS_CYC + 4)) begin
                        o_rdata       <= link.dev_dq;
                        o_rvalid      <= 1'b1;
                        link.select_n <= 1'b1;
                        link.out_en_n <= 1'b1;
                        cnt_r         <= '0;
                        state_r       <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'h3) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // flash_protect_host

// ==== flash_protect_assertions.sv ====
// concurrent checks on the flash link pins and the device status outputs
// assumes one instance beside the link interface, every signal by name
`timescale 1ns/10ps
`include "flash_protect_params.svh"
module flash_protect_assertions (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic select_n,
    input wire logic out_en_n,
    input wire logic hw_reset_n,
    input wire logic prog_volt,
    input wire logic supply_low,
    input wire logic dev_dq_oe,
    input wire logic busy,
    input wire logic o_array_write,
    input wire logic o_standby,
    input wire logic o_lock_bit
);
    localparam int OP_MAX = `OPERATION_CYC;
    int busy_run;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ============================================================
    // helpers
    // run length of busy; a stuck busy would otherwise pass unnoticed
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst)
            busy_run <= 0;
        else
            busy_run <= busy ? busy_run + 1 : 0;
    end
    // ============================================================
    // assertions; repeats of 4, 5 and 8 cover the two-flop pin sync
    a_float_oe_high: assert property (out_en_n [*4] |-> !dev_dq_oe)
        else $error("data bus driven while output enable is high");
    a_float_in_standby: assert property (o_standby |-> !dev_dq_oe)
        else $error("data bus driven in standby");
    a_standby_entry: assert property ((select_n && hw_reset_n && !busy) [*4] |-> o_standby)
        else $error("standby not entered while deselected and idle");
    a_volt_blocks_write: assert property ((!prog_volt) [*8] |-> !o_array_write)
        else $error("array write with program voltage low");
    a_supply_blocks_write: assert property (supply_low [*8] |-> !o_array_write)
        else $error("array write during supply lockout");
    a_select_blocks_write: assert property (select_n [*8] |-> !o_array_write)
        else $error("array write while deselected");
    a_reset_idles_all: assert property ((!hw_reset_n) [*5] |-> !busy && !dev_dq_oe)
        else $error("device active during hardware reset");
    a_busy_min_poll: assert property (disable iff (i_rst || !hw_reset_n)
        $rose(busy) |-> busy [*4])
        else $error("busy shorter than the status poll");
    a_busy_max_run: assert property (busy_run <= OP_MAX)
        else $error("busy longer than one operation");
    a_lock_sticky: assert property (o_lock_bit |=> o_lock_bit)
        else $error("lock bit cleared without power cycle");
    c_poll_only: cover property ($rose(busy) ##4 !busy);
    c_array_write: cover property (o_array_write);
    c_standby: cover property ($rose(o_standby));
endmodule // flash_protect_assertions

// ==== flash_sector_protect_and_id_tb.sv ====
// self-checking bench: host end and device end joined by the link interface
// assumes package, params header, interface and both ends compiled first
`timescale 1ns/10ps
`include "flash_protect_params.svh"
module flash_sector_protect_and_id_tb;
    import flash_protect_pkg::*;
    logic  i_clock = 1'b0;
    logic  i_rst = 1'b1;
    logic  req = 1'b0, wr = 1'b0, pv = 1'b1, sl = 1'b0, rel = 1'b0;
    logic  ready, rvalid, awr, stby, lockb;
    addr_t addr = '0;
    data_t wdata = '0;
    data_t arr = 16'hC3E1;
    data_t rdata, rd;
    int    miscompares = 0, tests_run = 0, writes = 0, busy_cyc = 0;
    flash_link_if link ();
    flash_protect_device i_flash_protect_device (.i_clock(i_clock), .i_rst(i_rst),
        .i_clk_en(1'b1), .link(link.device), .i_array_data(arr), .o_array_write(awr),
        .o_standby(stby), .o_lock_bit(lockb));
    flash_protect_host i_flash_protect_host (.i_clock(i_clock), .i_rst(i_rst),
        .i_clk_en(1'b1), .link(link.host), .i_req(req), .i_write(wr), .i_addr(addr),
        .i_wdata(wdata), .i_prog_volt(pv), .i_supply_low(sl), .i_release_reset(rel),
        .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata));
    flash_protect_assertions i_flash_protect_assertions (.i_clock(i_clock), .i_rst(i_rst),
        .select_n(link.select_n), .out_en_n(link.out_en_n), .hw_reset_n(link.hw_reset_n),
        .prog_volt(link.prog_volt), .supply_low(link.supply_low), .dev_dq_oe(link.dev_dq_oe),
        .busy(link.busy), .o_array_write(awr), .o_standby(stby), .o_lock_bit(lockb));
    always #5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        writes <= writes + int'(awr === 1'b1);
        busy_cyc <= busy_cyc + int'(link.busy === 1'b1);
    end
    // ============================================================
    // shared tasks
    function automatic addr_t sa(input int s, input int low);
        return {s[5:0], low[15:0]};
    endfunction
    task automatic chk(input data_t got, input data_t exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one host request; a write also waits out any busy it started
    task automatic xfer(input logic w, input addr_t a, input data_t d);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 500) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        {req, wr, addr, wdata} = {1'b1, w, a, d};
        do begin
            @(posedge i_clock);
            #1;
            n++;
            req = 1'b0;
            if (rvalid === 1'b1)
                rd = rdata;
        end while ((w ? ready : rvalid) !== 1'b1 && n < 500);
        while (w && link.busy === 1'b1 && n < 500) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        if (n >= 500)
            chk(16'h0000, 16'h0001);
    endtask
    task automatic rd_chk(input addr_t a, input data_t exp);
        xfer(1'b0, a, '0);
        chk(rd, exp);
    endtask
    task automatic cmd(input int s, input logic [7:0] c);
        xfer(1'b1, sa(s, 0), {8'h00, c});
    endtask
    task automatic status(input int s, input logic exp);
        cmd(s, `CMD_DPB_STATUS);
        rd_chk(sa(s, 0), {15'h0000, exp});
        cmd(s, `CMD_RESET);
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches %0d", name, miscompares);
    endtask
    // ============================================================
    // scenarios
    task automatic t_ident();
        cmd(0, `CMD_QUERY);
        rd_chk(sa(0, 0), `ID_MAKER);
        rd_chk(sa(0, 1), `ID_DEVICE);
        rd_chk(sa(9, 3), 16'h0000);
        cmd(0, `CMD_RESET);
        rd_chk(sa(0, 0), arr);
        status(0, 1'b1);
        status(63, 1'b1);
        done("ident");
    endtask
    task automatic t_protect_bits();
        cmd(5, `CMD_DPB_SET);
        status(5, 1'b0);
        cmd(5, `CMD_QUERY);
        rd_chk(sa(5, 16'h07A6), 16'h0001);
        cmd(5, `CMD_RESET);
        status(4, 1'b1);
        cmd(5, `CMD_DPB_CLEAR);
        status(5, 1'b1);
        cmd(5, `CMD_DPB_SET);
        status(5, 1'b0);
        done("protect_bits");
    endtask
    task automatic t_guard();
        int w0, b0;
        w0 = writes;
        b0 = busy_cyc;
        cmd(5, `CMD_PROGRAM);
        chk(16'(writes - w0), 16'h0000);
        chk(16'(busy_cyc - b0), 16'(`POLL_CYC));
        w0 = writes;
        b0 = busy_cyc;
        cmd(6, `CMD_ERASE);
        chk(16'(writes - w0), 16'h0001);
        chk(16'(busy_cyc - b0), 16'(`OPERATION_CYC));
        done("guard");
    endtask
    task automatic t_pins();
        int w0;
        pv = 1'b0;
        w0 = writes;
        cmd(6, `CMD_PROGRAM);
        chk(16'(writes - w0), 16'h0000);
        pv = 1'b1;
        sl = 1'b1;
        cmd(7, `CMD_DPB_SET);
        sl = 1'b0;
        status(7, 1'b1);
        done("pins");
    endtask
    task automatic t_lock();
        cmd(0, `CMD_LOCK_PROGRAM);
        chk({15'h0000, lockb}, 16'h0001);
        status(5, 1'b1);
        cmd(0, `CMD_QUERY);
        rd_chk(sa(0, 3), 16'h0001);
        cmd(0, `CMD_RESET);
        done("lock");
    endtask
    task automatic t_bank();
        xfer(1'b1, {3'b010, 19'h0}, {8'h01, `CMD_QUERY});
        rd_chk({3'b010, 19'h0}, `ID_MAKER);
        rd_chk({3'b101, 19'h0}, arr);
        rd_chk({3'b010, 19'h1}, `ID_DEVICE);
        cmd(16, `CMD_RESET);
        done("bank");
    endtask
    task automatic t_standby();
        for (int n = 0; n < 10 && stby !== 1'b1; n++) begin
            @(posedge i_clock);
            #1;
        end
        chk({15'h0000, stby}, 16'h0001);
        chk({15'h0000, link.dev_dq_oe}, 16'h0000);
        chk(link.dq, 16'h0000);
        rd_chk(sa(2, 0), arr);
        done("standby");
    endtask
    task automatic t_hwreset();
        cmd(3, `CMD_DPB_SET);
        rel = 1'b0;
        for (int n = 0; n < 10 && link.hw_reset_n !== 1'b0; n++) begin
            @(posedge i_clock);
            #1;
        end
        // hold reset long enough for the synced pin to idle the device
        repeat (6) @(posedge i_clock);
        #1;
        rel = 1'b1;
        status(3, 1'b1);
        done("hwreset");
    endtask
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ============================================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        rel = 1'b1;
        t_ident();
        t_protect_bits();
        t_guard();
        t_pins();
        t_lock();
        t_bank();
        t_standby();
        t_hwreset();
        final_report();
    end
    // about 50 requests of under 40 cycles each; ten times that is ample
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
endmodule // flash_sector_protect_and_id_tb
